// file: logic/output_channel_safe_state_diag.sv
/*
 Eight-channel sourcing output: safe states, diagnostics, Wishbone registers.
 Assumes pins are asynchronous levels and a classic Wishbone master on sys_clk.
*/
`timescale 1ns/1ns
module output_channel_safe_state_diag #(
    parameter int CYC_PER_SEC = out_safe_pkg::CYCLES_PER_SEC
) (
    input  wire logic                             sys_clk,
    input  wire logic                             sys_rst,
    input  wire logic                             wb_cyc_i,
    input  wire logic                             wb_stb_i,
    input  wire logic                             wb_we_i,
    input  wire logic [out_safe_pkg::ADR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]                       wb_sel_i,
    input  wire logic [31:0]                      wb_dat_i,
    output logic      [31:0]                      wb_dat_o,
    output logic                                  wb_ack_o,
    input  wire logic                             link_running,
    input  wire logic                             run_request,
    input  wire logic [out_safe_pkg::NUM_CH-1:0]  open_load_sense,
    input  wire logic [out_safe_pkg::NUM_CH-1:0]  overcurrent_sense,
    input  wire logic                             field_power_ok,
    output logic      [out_safe_pkg::NUM_CH-1:0]  out_drive,
    output logic                                  irq
);
    import out_safe_pkg::*;

    typedef struct packed {
        logic [NUM_CH-1:0]   cmd;
        logic [NUM_CH-1:0]   flt_sel;
        logic [NUM_CH-1:0]   flt_val;
        logic [NUM_CH-1:0]   prg_sel;
        logic [NUM_CH-1:0]   prg_val;
        logic [NUM_CH-1:0]   fin_val;
        logic [NUM_CH-1:0]   prg2flt;
        logic [NUM_CH-1:0]   ol_en;
        logic [8*NUM_CH-1:0] hold;
        logic [NUM_CH-1:0]   ol_flag;
        logic [NUM_CH-1:0]   oc_flag;
        logic [NUM_CH-1:0]   flt_flag;
        logic [NUM_CH-1:0]   unc_flag;
        logic                link_down_flag;
        logic                run_state_flag;
        logic [IRQ_W-1:0]    ists;
        logic [IRQ_W-1:0]    imask;
        logic                ack;
        logic [31:0]         rdata;
        logic                irq;
    } top_state_t;

    top_state_t        r_reg;
    top_state_t        r_next;
    logic [SYNC_W-1:0] pin_sync;
    logic              link_s;
    logic              run_s;
    logic [NUM_CH-1:0] ol_s;
    logic [NUM_CH-1:0] oc_s;
    logic              pwr_s;
    logic              pwr_lost_s;
    logic [NUM_CH-1:0] drive;
    logic [NUM_CH-1:0] subst;
    logic              req;
    logic              wr;
    logic [IRQ_W-1:0]  events;
    logic [IRQ_W-1:0]  w1c;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    bit_sync #(
        .WIDTH (SYNC_W)
    ) u_pin_sync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .d       ({link_running, run_request, open_load_sense, overcurrent_sense, !field_power_ok}),
        .q       (pin_sync)
    );
    // Power sense inverted so the sync reset reads as powered, no false fault event
    assign {link_s, run_s, ol_s, oc_s, pwr_lost_s} = pin_sync;
    assign pwr_s = !pwr_lost_s;

    ////////////////////////////////////////////////////////////////////////
    // Channels
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            channel_safe_state #(
                .CYC_PER_SEC (CYC_PER_SEC)
            ) u_ch (
                .sys_clk       (sys_clk),
                .sys_rst       (sys_rst),
                .link_down     (r_reg.link_down_flag),
                .run_mode      (r_reg.run_state_flag),
                .cmd_value     (r_reg.cmd[gi]),
                .fault_sel     (r_reg.flt_sel[gi]),
                .fault_value   (r_reg.flt_val[gi]),
                .prog_sel      (r_reg.prg_sel[gi]),
                .prog_value    (r_reg.prg_val[gi]),
                .final_value   (r_reg.fin_val[gi]),
                .prog_to_fault (r_reg.prg2flt[gi]),
                .hold_code     (r_reg.hold[8*gi +: 8]),
                .drive_out     (drive[gi]),
                .substituted   (subst[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Byte-lane merge for wide registers
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    assign req = wb_cyc_i && wb_stb_i && !r_reg.ack;
    assign wr  = req && wb_we_i;
    assign w1c = (wr && wb_adr_i == ADR_IRQ_STS) ? IRQ_W'(lane_merge(32'h0, wb_dat_i, wb_sel_i)) : '0;

    always_comb begin
        r_next = r_reg;

        // Diagnostics follow their causes; no latching so they clear alone
        r_next.ol_flag        = ol_s & r_reg.ol_en; // [RULE8] [RULE9] [RULE13]
        r_next.oc_flag        = oc_s; // [RULE10]
        r_next.flt_flag       = {NUM_CH{!pwr_s}} | r_next.ol_flag | r_next.oc_flag; // [RULE11] [RULE13]
        r_next.unc_flag       = subst; // [RULE12] [RULE13]
        r_next.link_down_flag = !link_s; // [RULE16]
        r_next.run_state_flag = run_s; // [RULE17]

        events = {r_next.run_state_flag ^ r_reg.run_state_flag,
                  r_next.link_down_flag & ~r_reg.link_down_flag,
                  r_next.flt_flag & ~r_reg.flt_flag};
        // A new event wins over a same-cycle clear
        r_next.ists = (r_reg.ists & ~w1c) | events;

        if (wr && wb_sel_i[0]) begin
            unique case (wb_adr_i)
                ADR_OUT_CMD:   r_next.cmd     = wb_dat_i[NUM_CH-1:0]; // [RULE15]
                ADR_FLT_SEL:   r_next.flt_sel = wb_dat_i[NUM_CH-1:0];
                ADR_FLT_VAL:   r_next.flt_val = wb_dat_i[NUM_CH-1:0];
                ADR_PRG_SEL:   r_next.prg_sel = wb_dat_i[NUM_CH-1:0];
                ADR_PRG_VAL:   r_next.prg_val = wb_dat_i[NUM_CH-1:0];
                ADR_FINAL_VAL: r_next.fin_val = wb_dat_i[NUM_CH-1:0];
                ADR_PRG2FLT:   r_next.prg2flt = wb_dat_i[NUM_CH-1:0];
                ADR_OL_EN:     r_next.ol_en   = wb_dat_i[NUM_CH-1:0];
                default: ;
            endcase
        end
        if (wr && wb_adr_i == ADR_HOLD_LO) begin
            r_next.hold[31:0] = lane_merge(r_reg.hold[31:0], wb_dat_i, wb_sel_i);
        end
        if (wr && wb_adr_i == ADR_HOLD_HI) begin
            r_next.hold[63:32] = lane_merge(r_reg.hold[63:32], wb_dat_i, wb_sel_i);
        end
        if (wr && wb_adr_i == ADR_IRQ_MASK) begin
            r_next.imask = IRQ_W'(lane_merge(32'(r_reg.imask), wb_dat_i, wb_sel_i));
        end

        r_next.ack   = req;
        r_next.rdata = 32'h0;
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                ADR_OUT_CMD:   r_next.rdata = 32'(r_reg.cmd);
                ADR_FLT_SEL:   r_next.rdata = 32'(r_reg.flt_sel);
                ADR_FLT_VAL:   r_next.rdata = 32'(r_reg.flt_val);
                ADR_PRG_SEL:   r_next.rdata = 32'(r_reg.prg_sel);
                ADR_PRG_VAL:   r_next.rdata = 32'(r_reg.prg_val);
                ADR_FINAL_VAL: r_next.rdata = 32'(r_reg.fin_val);
                ADR_PRG2FLT:   r_next.rdata = 32'(r_reg.prg2flt);
                ADR_OL_EN:     r_next.rdata = 32'(r_reg.ol_en);
                ADR_HOLD_LO:   r_next.rdata = r_reg.hold[31:0];
                ADR_HOLD_HI:   r_next.rdata = r_reg.hold[63:32];
                ADR_STATUS:    r_next.rdata = {30'h0, r_reg.run_state_flag, r_reg.link_down_flag}; // [RULE16] [RULE17]
                ADR_CH_DATA:   r_next.rdata = 32'(drive); // [RULE14]
                ADR_OL_FLAG:   r_next.rdata = 32'(r_reg.ol_flag);
                ADR_OC_FLAG:   r_next.rdata = 32'(r_reg.oc_flag);
                ADR_FLT_FLAG:  r_next.rdata = 32'(r_reg.flt_flag);
                ADR_UNC_FLAG:  r_next.rdata = 32'(r_reg.unc_flag);
                ADR_IRQ_STS:   r_next.rdata = 32'(r_reg.ists);
                ADR_IRQ_MASK:  r_next.rdata = 32'(r_reg.imask);
                default:       r_next.rdata = 32'h0;
            endcase
        end
        r_next.irq = |(r_next.ists & r_next.imask);
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            r_reg                <= '0;
            r_reg.cmd            <= CH_RESET;
            r_reg.hold           <= HOLD_RESET;
            r_reg.ists           <= IRQ_RESET;
            r_reg.imask          <= IRQ_RESET;
            r_reg.link_down_flag <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign out_drive = drive;
    assign wb_ack_o  = r_reg.ack;
    assign wb_dat_o  = r_reg.rdata;
    assign irq       = r_reg.irq;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    open_load_gate_a: assert property (##3 r_reg.ol_flag == ($past(open_load_sense, 3) & $past(r_reg.ol_en))) // [RULE8]
        else $error("open-load flag not gated by enable");
    open_load_set_a: assert property (##3 (r_reg.ol_flag & ~$past(open_load_sense, 3)) == '0) // [RULE9]
        else $error("open-load flag without cause");
    short_flag_a: assert property (##3 r_reg.oc_flag == $past(overcurrent_sense, 3)) // [RULE10]
        else $error("overcurrent flag mismatch");
    fault_cause_a: assert property (r_reg.flt_flag == ({NUM_CH{!$past(pwr_s)}} | r_reg.ol_flag | r_reg.oc_flag)) // [RULE11]
        else $error("fault flag mismatch");
    uncertain_a: assert property (!$past(sys_rst) |-> r_reg.unc_flag == $past(subst)) // [RULE12]
        else $error("uncertain flag mismatch");
    link_flag_a: assert property (!$past(sys_rst, 3) |-> r_reg.link_down_flag == !$past(link_running, 3)) // [RULE16]
        else $error("link-down flag mismatch");
    run_flag_a: assert property (!$past(sys_rst, 3) |-> r_reg.run_state_flag == $past(run_request, 3)) // [RULE17]
        else $error("run-state flag mismatch");
    irq_level_a: assert property (r_reg.irq == |(r_reg.ists & r_reg.imask))
        else $error("interrupt level mismatch");
endmodule // output_channel_safe_state_diag

// file: include/out_safe_pkg.sv
/*
 Shared constants for the output channel safe-state and diagnostic block.
 Assumes one 10 MHz clock and a classic Wishbone slave port.
*/
// Operation
// [RULE1] Comm fault: hold last or user value
// [RULE2] Fault user value bit: 0 Off, 1 On
// [RULE3] Program entry: hold last or user value
// [RULE4] Program user value bit: 0 Off, 1 On
// [RULE5] Fault hold time: forever, 1/2/5/10 s
// [RULE6] Hold time expiry drives final value bit
// [RULE7] Fault during program obeys program-to-fault enable
// [RULE8] Open-load detection only while enabled
// [RULE9] Open load sets channel open-load flag
// [RULE10] Short or overcurrent sets overcurrent flag
// [RULE11] Power loss, open load, short set fault
// [RULE12] Uncertain flag marks possibly inaccurate data
// [RULE13] Fault and uncertain clear by themselves
// [RULE14] Status bit shows present channel value
// [RULE15] Controller supplies commanded output bits
// [RULE16] Link-down status bit: 1 when not running
// [RULE17] Run-state status bit: 1 in run
// [RULE18] Link and run restored: resume commanded value
package out_safe_pkg;
    localparam int NUM_CH         = 8;
    localparam int ADR_W          = 8;
    localparam int CLK_PERIOD_NS  = 100;
    localparam int SEC_NS         = 1000000000;
    localparam int CYCLES_PER_SEC = SEC_NS / CLK_PERIOD_NS;
    localparam int SYNC_W         = 2 * NUM_CH + 3;
    localparam int IRQ_LINK_BIT   = NUM_CH;
    localparam int IRQ_RUN_BIT    = NUM_CH + 1;
    localparam int IRQ_W          = NUM_CH + 2;

    localparam logic [ADR_W-1:0] ADR_OUT_CMD   = 8'h00;
    localparam logic [ADR_W-1:0] ADR_FLT_SEL   = 8'h04;
    localparam logic [ADR_W-1:0] ADR_FLT_VAL   = 8'h08;
    localparam logic [ADR_W-1:0] ADR_PRG_SEL   = 8'h0c;
    localparam logic [ADR_W-1:0] ADR_PRG_VAL   = 8'h10;
    localparam logic [ADR_W-1:0] ADR_FINAL_VAL = 8'h14;
    localparam logic [ADR_W-1:0] ADR_PRG2FLT   = 8'h18;
    localparam logic [ADR_W-1:0] ADR_OL_EN     = 8'h1c;
    localparam logic [ADR_W-1:0] ADR_HOLD_LO   = 8'h20;
    localparam logic [ADR_W-1:0] ADR_HOLD_HI   = 8'h24;
    localparam logic [ADR_W-1:0] ADR_STATUS    = 8'h28;
    localparam logic [ADR_W-1:0] ADR_CH_DATA   = 8'h2c;
    localparam logic [ADR_W-1:0] ADR_OL_FLAG   = 8'h30;
    localparam logic [ADR_W-1:0] ADR_OC_FLAG   = 8'h34;
    localparam logic [ADR_W-1:0] ADR_FLT_FLAG  = 8'h38;
    localparam logic [ADR_W-1:0] ADR_UNC_FLAG  = 8'h3c;
    localparam logic [ADR_W-1:0] ADR_IRQ_STS   = 8'h40;
    localparam logic [ADR_W-1:0] ADR_IRQ_MASK  = 8'h44;

    localparam logic [NUM_CH-1:0]   CH_RESET   = 8'h00;
    localparam logic [8*NUM_CH-1:0] HOLD_RESET = 64'h0;
    localparam logic [IRQ_W-1:0]    IRQ_RESET  = 10'h000;
    localparam logic [31:0]         CNT_RESET  = 32'h0;

    localparam logic [7:0] HOLD_FOREVER = 8'h00;
    localparam logic [7:0] HOLD_1S      = 8'h01;
    localparam logic [7:0] HOLD_2S      = 8'h02;
    localparam logic [7:0] HOLD_5S      = 8'h05;
    localparam logic [7:0] HOLD_10S     = 8'h0a;

    typedef enum logic [1:0] {
        CH_PROG  = 2'b00,
        CH_RUN   = 2'b01,
        CH_FAULT = 2'b10,
        CH_FINAL = 2'b11
    } ch_state_t;
endpackage

// file: logic/bit_sync.sv
/*
 Two-flop synchroniser for a vector of independent level pins.
 Assumes each bit is a slow level; no bus coherence is kept across bits.
*/
`timescale 1ns/1ns
module bit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sync_state_t;

    sync_state_t r_reg;
    sync_state_t r_next;

    always_comb begin
        r_next.s1 = d;
        r_next.s2 = r_reg.s1;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign q = r_reg.s2;
endmodule // bit_sync

// file: logic/channel_safe_state.sv
/*
 One output channel: run, program, fault and final-state sequencing.
 Assumes link_down and run_mode are already synchronised to sys_clk.
*/
`timescale 1ns/1ns
module channel_safe_state
    import out_safe_pkg::*;
#(
    parameter int CYC_PER_SEC = out_safe_pkg::CYCLES_PER_SEC
) (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       link_down,
    input  wire logic       run_mode,
    input  wire logic       cmd_value,
    input  wire logic       fault_sel,
    input  wire logic       fault_value,
    input  wire logic       prog_sel,
    input  wire logic       prog_value,
    input  wire logic       final_value,
    input  wire logic       prog_to_fault,
    input  wire logic [7:0] hold_code,
    output logic            drive_out,
    output logic            substituted
);
    import out_safe_pkg::*;

    typedef struct packed {
        ch_state_t   st;
        logic        out;
        logic [31:0] cnt;
    } ch_reg_t;

    ch_reg_t     r_reg;
    ch_reg_t     r_next;
    logic [3:0]  secs;
    logic [31:0] limit;

    ////////////////////////////////////////////////////////////////////////
    // Unlisted codes fall back to hold forever, the safe choice
    always_comb begin
        unique case (hold_code)
            HOLD_1S:  secs = 4'd1;
            HOLD_2S:  secs = 4'd2;
            HOLD_5S:  secs = 4'd5;
            HOLD_10S: secs = 4'd10;
            default:  secs = 4'd0;
        endcase
    end
    assign limit = 32'(secs) * 32'(CYC_PER_SEC); // [RULE5]

    always_comb begin
        r_next = r_reg;
        unique case (r_reg.st)
            CH_PROG: begin
                if (link_down && prog_to_fault) begin // [RULE7]
                    r_next.st = CH_FAULT;
                end else if (!link_down && run_mode) begin // [RULE18]
                    r_next.st = CH_RUN;
                end
            end
            CH_RUN: begin
                if (link_down) begin
                    r_next.st = CH_FAULT;
                end else if (!run_mode) begin
                    r_next.st = CH_PROG;
                end
            end
            CH_FAULT, CH_FINAL: begin
                if (!link_down) begin
                    r_next.st = run_mode ? CH_RUN : CH_PROG; // [RULE18]
                end else if (r_reg.st == CH_FAULT && limit != CNT_RESET && r_reg.cnt == limit - 32'd1) begin
                    r_next.st = CH_FINAL; // [RULE6]
                end
            end
        endcase
        // Counter only runs while a finite hold is pending
        if (r_next.st == CH_FAULT && r_reg.st == CH_FAULT && limit != CNT_RESET) begin
            r_next.cnt = r_reg.cnt + 32'd1; // [RULE5]
        end else begin
            r_next.cnt = CNT_RESET;
        end
        unique case (r_next.st)
            CH_RUN:   r_next.out = cmd_value; // [RULE18]
            CH_PROG:  r_next.out = prog_sel ? prog_value : r_reg.out; // [RULE3] [RULE4]
            CH_FAULT: r_next.out = fault_sel ? fault_value : r_reg.out; // [RULE1] [RULE2]
            CH_FINAL: r_next.out = final_value; // [RULE6]
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            r_reg <= '{st: CH_PROG, out: 1'b0, cnt: CNT_RESET};
        end else begin
            r_reg <= r_next;
        end
    end

    assign drive_out   = r_reg.out;
    assign substituted = (r_reg.st != CH_RUN);

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence resume_s;
        !link_down && run_mode;
    endsequence
    sequence fault_hold_s;
        r_reg.st == CH_FAULT && link_down && !fault_sel;
    endsequence

    fault_hold_a: assert property (fault_hold_s ##1 r_reg.st == CH_FAULT |-> $stable(r_reg.out)) // [RULE1]
        else $error("fault hold changed output");
    fault_value_a: assert property (r_reg.st == CH_FAULT && $past(fault_sel) |-> r_reg.out == $past(fault_value)) // [RULE2]
        else $error("fault user value not driven");
    prog_value_a: assert property (r_reg.st == CH_PROG && $past(prog_sel) |-> r_reg.out == $past(prog_value)) // [RULE4]
        else $error("program user value not driven");
    prog_hold_a: assert property ($past(r_reg.st) == CH_PROG && r_reg.st == CH_PROG && !$past(prog_sel)
                                  |-> $stable(r_reg.out)) // [RULE3]
        else $error("program hold changed output");
    forever_hold_a: assert property (r_reg.st == CH_FAULT && link_down && secs == 4'd0 |=> r_reg.st == CH_FAULT) // [RULE5]
        else $error("forever hold left fault state");
    final_value_a: assert property (r_reg.st == CH_FINAL |-> r_reg.out == $past(final_value)) // [RULE6]
        else $error("final value not driven");
    prog_stay_a: assert property (r_reg.st == CH_PROG && link_down && !prog_to_fault |=> r_reg.st == CH_PROG) // [RULE7]
        else $error("program state left on link fault");
    resume_cmd_a: assert property (resume_s |=> r_reg.st == CH_RUN && r_reg.out == $past(cmd_value)) // [RULE18]
        else $error("commanded value not resumed");
endmodule // channel_safe_state

// file: verif/owner_field_model.sv
/*
 Owner controller link pins and field wiring behind the output pins.
 Assumes the bench sets the commands by non-blocking assignment.
*/
`timescale 1ns/1ns
module owner_field_model (
    input  wire logic       sys_clk,
    input  wire logic       link_cmd,
    input  wire logic       run_cmd,
    input  wire logic       pwr_cmd,
    input  wire logic [7:0] cut,
    input  wire logic [7:0] short_ch,
    input  wire logic [7:0] out_drive,
    output logic            link_running,
    output logic            run_request,
    output logic            field_power_ok,
    output logic      [7:0] open_load_sense,
    output logic      [7:0] overcurrent_sense
);
    // Pins move one edge late, like a cyclic link
    always_ff @(posedge sys_clk) begin
        link_running      <= link_cmd;
        run_request       <= run_cmd;
        field_power_ok    <= pwr_cmd;
        open_load_sense   <= cut;
        // Overcurrent only shows while sourcing
        overcurrent_sense <= short_ch & out_drive;
    end
endmodule // owner_field_model

// file: verif/output_channel_safe_state_diag_tb.sv
/*
 Self-checking bench for the output safe-state block.
 Assumes one 10 MHz clock and one second shortened to 10 cycles.
*/
`timescale 1ns/1ns
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("[ERR] %s exp %h got %h", n, e, a); end end
module output_channel_safe_state_diag_tb;
    import out_safe_pkg::*;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, wen = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0, rdat, q;
    logic        ack, irq, link, run, pwr;
    logic        link_c = 1'b1, run_c = 1'b1, pwr_c = 1'b1;
    logic [7:0]  cut = 8'h00, sh = 8'h00, drv, ol, oc;
    logic [7:0]  cmd, fs, fv, ps, pv, fin, p2f, en, e, fe;
    int          error_cnt = 0, checks = 0, el = 0, tc = 0;
    int          ks[4] = '{1, 2, 5, 10};

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end

    output_channel_safe_state_diag #(.CYC_PER_SEC(10)) output_channel_safe_state_diag_i (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(wen), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .link_running(link), .run_request(run),
        .open_load_sense(ol), .overcurrent_sense(oc), .field_power_ok(pwr),
        .out_drive(drv), .irq(irq));

    owner_field_model owner_field_model_i (
        .sys_clk(sys_clk), .link_cmd(link_c), .run_cmd(run_c), .pwr_cmd(pwr_c),
        .cut(cut), .short_ch(sh), .out_drive(drv), .link_running(link),
        .run_request(run), .field_power_ok(pwr), .open_load_sense(ol),
        .overcurrent_sense(oc));

    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        el += n;
    endtask

    // Ack sampled at the rising edge; only the global timeout ends a hang
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        wen <= we;
        adr <= a;
        dat <= d;
        @(posedge sys_clk);
        while (ack !== 1'b1) begin
            @(posedge sys_clk);
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string n);
        wb(1'b0, a, 32'h0);
        `CHK(n, ex, q)
    endtask

    task automatic summarize();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        tc++;
        if (tc == 3000) begin
            error_cnt++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(17));
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        tick(8);
        rd(ADR_STATUS, 32'h2, "status");
        cmd = 8'($urandom);
        wb(1'b1, ADR_OUT_CMD, {24'h0, cmd});
        tick(2);
        `CHK("drive", cmd, drv)
        rd(ADR_CH_DATA, {24'h0, cmd}, "data");
        rd(ADR_UNC_FLAG, 32'h0, "unc");
        rd(8'h80, 32'h0, "unmapped");
        $display("test run done");
        fs = 8'($urandom);
        fv = 8'($urandom);
        wb(1'b1, ADR_FLT_SEL, {24'h0, fs});
        wb(1'b1, ADR_FLT_VAL, {24'h0, fv});
        wb(1'b1, ADR_IRQ_STS, 32'h3ff);
        wb(1'b1, ADR_IRQ_MASK, 32'h100);
        link_c <= 1'b0;
        tick(8);
        fe = (fs & fv) | (~fs & cmd);
        `CHK("drive", fe, drv)
        rd(ADR_STATUS, 32'h3, "status");
        `CHK("irq", 1'b1, irq)
        rd(ADR_UNC_FLAG, 32'hff, "unc");
        wb(1'b1, ADR_IRQ_STS, 32'h100);
        tick(1);
        `CHK("irq", 1'b0, irq)
        link_c <= 1'b1;
        tick(8);
        `CHK("drive", cmd, drv)
        rd(ADR_UNC_FLAG, 32'h0, "unc");
        $display("test fault done");
        fin = 8'($urandom);
        wb(1'b1, ADR_FINAL_VAL, {24'h0, fin});
        wb(1'b1, ADR_HOLD_LO, 32'h0a050201);
        link_c <= 1'b0;
        el = 0;
        foreach (ks[i]) begin
            tick(ks[i] * 10 + 8 - el);
            e = fe;
            for (int c = 0; c < 4; c++) e[c] = (ks[c] <= ks[i]) ? fin[c] : fe[c];
            `CHK("hold", e, drv)
        end
        link_c <= 1'b1;
        wb(1'b1, ADR_HOLD_LO, 32'h0);
        tick(8);
        `CHK("drive", cmd, drv)
        $display("test hold done");
        ps = 8'($urandom);
        pv = 8'($urandom);
        p2f = 8'($urandom);
        wb(1'b1, ADR_PRG_SEL, {24'h0, ps});
        wb(1'b1, ADR_PRG_VAL, {24'h0, pv});
        wb(1'b1, ADR_PRG2FLT, {24'h0, p2f});
        run_c <= 1'b0;
        tick(8);
        e = (ps & pv) | (~ps & cmd);
        `CHK("drive", e, drv)
        rd(ADR_STATUS, 32'h0, "status");
        link_c <= 1'b0;
        tick(8);
        fe = (fs & fv) | (~fs & e);
        `CHK("drive", (p2f & fe) | (~p2f & e), drv)
        link_c <= 1'b1;
        run_c <= 1'b1;
        tick(8);
        `CHK("drive", cmd, drv)
        $display("test program done");
        en = 8'($urandom);
        wb(1'b1, ADR_OL_EN, {24'h0, en});
        cut <= 8'($urandom);
        sh <= 8'($urandom);
        tick(8);
        rd(ADR_OL_FLAG, {24'h0, cut & en}, "ol");
        rd(ADR_OC_FLAG, {24'h0, sh & cmd}, "oc");
        rd(ADR_FLT_FLAG, {24'h0, (cut & en) | (sh & cmd)}, "flt");
        pwr_c <= 1'b0;
        tick(8);
        rd(ADR_FLT_FLAG, 32'hff, "flt");
        pwr_c <= 1'b1;
        cut <= 8'h00;
        sh <= 8'h00;
        tick(8);
        rd(ADR_FLT_FLAG, 32'h0, "flt");
        $display("test diag done");
        summarize();
    end
endmodule // output_channel_safe_state_diag_tb
